/* hw/scd_top.sv */
// Strap configuration decoder with APB status and control registers
//
// The APB interface to the registers and the address map were left to the implementer.
`timescale 1ns/10ps
module scd_top #(
  parameter int ADDR_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Board straps
  input wire logic [3:0] test_mode_select,
  input wire logic [2:0] phy_mode_select,
  input wire logic boot_select,
  // Raw PLL lock and PHY negotiation status
  input wire logic pll_locked,
  input wire logic an_complete,
  input wire logic an_speed_100,
  input wire logic an_full_duplex,
  // Outputs to PHY, boot logic and board
  output logic pll_lock_out,
  output scd_pkg::scd_phy_cfg_type phy_cfg,
  output logic an_restart,
  output logic boot_rom_enable,
  output logic app_jump,
  output logic [15:0] app_start_addr,
  output logic test_mode_active,
  output logic strap_valid,
  output logic link_speed_led,
  output logic duplex_led
);
  // Capture sequencer states
  typedef enum logic [0:0] {SCD_WAIT, SCD_HOLD} scd_state_type;

  // Synchronised pins
  logic [11:0] sync_bus;
  // Synchronised strap view
  scd_pkg::scd_strap_type strap_sync;
  // Straps latched once after reset
  scd_pkg::scd_strap_type captured;
  // Decoder result
  scd_pkg::scd_phy_cfg_type decoded;
  // Synchronised status bits
  logic lock_sync;
  logic an_done_sync;
  logic an_speed_sync;
  logic an_full_sync;
  // Sequencer
  scd_state_type state;
  logic [2:0] wait_cnt;
  // Software control
  logic led_blank;
  logic restart_req;
  // Resolved link state
  logic next_speed_100;
  logic next_full;
  // APB decode
  logic access;
  logic wr_en;
  logic [31:0] next_rdata;
  logic next_err;

  // All asynchronous inputs share one synchroniser
  scd_sync #(
    .WIDTH(scd_pkg::SCD_SYNC_W)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({test_mode_select, phy_mode_select, boot_select,
               pll_locked, an_complete, an_speed_100, an_full_duplex}),
    .sync_out(sync_bus)
  );

  // Split the synchronised bus
  assign strap_sync = sync_bus[11:4];
  assign lock_sync = sync_bus[3];
  assign an_done_sync = sync_bus[2];
  assign an_speed_sync = sync_bus[1];
  assign an_full_sync = sync_bus[0];

  // Mode decode of the held straps
  scd_phy_decode u_decode (
    .phy_mode_select(captured.phy_mode_select),
    .cfg(decoded)
  );

  // Capture sequencer: wait for the synchroniser to fill, then latch once.
  // Pins are never sampled under reset itself, only after release.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= SCD_WAIT;
      wait_cnt <= 3'h0;
      captured <= '0;
      strap_valid <= 1'b0;
    end
    else
    begin
      case (state)
        SCD_WAIT:
        begin
          // Count edges since release
          if (wait_cnt == scd_pkg::SCD_CAPTURE_WAIT - 3'h1)
          begin
            captured <= strap_sync;
            strap_valid <= 1'b1;
            state <= SCD_HOLD;
          end
          else
          begin
            wait_cnt <= wait_cnt + 3'h1;
          end
        end
        // Held until the next reset, later strap changes ignored
        SCD_HOLD:
        begin
          state <= SCD_HOLD;
        end
        default:
        begin
          state <= SCD_WAIT;
        end
      endcase
    end
  end

  // PHY configuration output; all off until straps are known
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      phy_cfg <= '0;
    end
    else if (strap_valid)
    begin
      phy_cfg <= decoded;
    end
  end

  // Boot path selection
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      boot_rom_enable <= 1'b0;
      app_jump <= 1'b0;
      app_start_addr <= scd_pkg::SCD_APP_START;
    end
    else if (strap_valid)
    begin
      boot_rom_enable <= captured.boot_select;
      app_jump <= !captured.boot_select;
      app_start_addr <= scd_pkg::SCD_APP_START;
    end
  end

  // Test-mode flag: anything but all zeros is not a service mode
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      test_mode_active <= 1'b0;
    end
    else
    begin
      test_mode_active <= strap_valid &&
        (captured.test_mode_select != scd_pkg::SCD_TM_NORMAL);
    end
  end

  // PLL lock reported after synchronising
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pll_lock_out <= 1'b0;
    end
    else
    begin
      pll_lock_out <= lock_sync;
    end
  end

  // Resolve speed and duplex from forced mode or negotiation result
  always_comb
  begin
    next_speed_100 = 1'b0;
    next_full = 1'b0;
    if (phy_cfg.an_enable)
    begin
      // Until negotiation ends, show 10 Mbit half duplex
      if (an_done_sync)
      begin
        next_speed_100 = an_speed_sync;
        next_full = an_full_sync;
      end
    end
    else
    begin
      next_speed_100 = phy_cfg.force_100;
      next_full = phy_cfg.force_full_duplex;
    end
  end

  // Indicator pins, active low; blanking turns both off
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      link_speed_led <= 1'b1;
      duplex_led <= 1'b1;
    end
    else
    begin
      link_speed_led <= !next_speed_100 || led_blank;
      duplex_led <= !next_full || led_blank;
    end
  end

  // APB access phase and write qualifier
  assign access = psel && penable;
  assign wr_en = access && pready && pwrite;

  // Read mux; unmapped offsets answer with an error
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    next_err = 1'b0;
    case (paddr)
      scd_pkg::SCD_OFF_STRAP:
      begin
        next_rdata[scd_pkg::SCD_ST_TM_LSB +: 4] = captured.test_mode_select;
        next_rdata[scd_pkg::SCD_ST_PM_LSB +: 3] = captured.phy_mode_select;
        next_rdata[scd_pkg::SCD_ST_BOOT] = captured.boot_select;
        next_rdata[scd_pkg::SCD_ST_VALID] = strap_valid;
        next_rdata[scd_pkg::SCD_ST_RSVD] = phy_cfg.reserved;
        next_rdata[scd_pkg::SCD_ST_TEST] = test_mode_active;
      end
      scd_pkg::SCD_OFF_STATUS:
      begin
        next_rdata[scd_pkg::SCD_SS_PLL] = pll_lock_out;
        next_rdata[scd_pkg::SCD_SS_AN_DONE] = an_done_sync;
        next_rdata[scd_pkg::SCD_SS_SPEED100] = next_speed_100;
        next_rdata[scd_pkg::SCD_SS_FULL] = next_full;
      end
      scd_pkg::SCD_OFF_CTRL:
      begin
        next_rdata[scd_pkg::SCD_CT_BLANK] = led_blank;
      end
      default:
      begin
        next_err = 1'b1;
      end
    endcase
  end

  // One wait state: pready rises in the second access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= access && !pready;
      pslverr <= access && !pready && next_err;
      if (access && !pready && !pwrite)
      begin
        prdata <= next_rdata;
      end
    end
  end

  // Control register; restart bit is write-one, self clearing
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      led_blank <= 1'b0;
      restart_req <= 1'b0;
    end
    else
    begin
      restart_req <= 1'b0;
      if (wr_en && paddr == scd_pkg::SCD_OFF_CTRL && pstrb[0])
      begin
        led_blank <= pwdata[scd_pkg::SCD_CT_BLANK];
        restart_req <= pwdata[scd_pkg::SCD_CT_RESTART];
      end
    end
  end

  // Restart pulse only meaningful while negotiating
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      an_restart <= 1'b0;
    end
    else
    begin
      an_restart <= restart_req && phy_cfg.an_enable;
    end
  end

  // Checks
  reset_clear_a: assert property (@(posedge pclk)
    !presetn |-> !strap_valid && !pll_lock_out && !phy_cfg.an_enable)
    else $error("outputs not cleared in reset");

  test_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    strap_valid |=> test_mode_active == ($past(captured.test_mode_select) != 4'h0))
    else $error("test mode flag wrong");

  an_all_a: assert property (@(posedge pclk) disable iff (!presetn)
    strap_valid && captured.phy_mode_select == 3'h0 |=> phy_cfg.an_enable && phy_cfg.adv == 4'hf)
    else $error("mode 000 not full autoneg");

  an_fast_a: assert property (@(posedge pclk) disable iff (!presetn)
    strap_valid && captured.phy_mode_select == 3'h1 |=> phy_cfg.an_enable && phy_cfg.adv == 4'hc)
    else $error("mode 001 wrong abilities");

  an_slow_a: assert property (@(posedge pclk) disable iff (!presetn)
    strap_valid && captured.phy_mode_select == 3'h2 |=> phy_cfg.an_enable && phy_cfg.adv == 4'h3)
    else $error("mode 010 wrong abilities");

  force_fast_a: assert property (@(posedge pclk) disable iff (!presetn)
    strap_valid && captured.phy_mode_select[2:1] == 2'b10 |=> !phy_cfg.an_enable
    && phy_cfg.force_100 && phy_cfg.force_full_duplex == !$past(captured.phy_mode_select[0]))
    else $error("forced 100 mode wrong");

  force_slow_a: assert property (@(posedge pclk) disable iff (!presetn)
    strap_valid && captured.phy_mode_select[2:1] == 2'b11 |=> !phy_cfg.an_enable
    && !phy_cfg.force_100 && phy_cfg.force_full_duplex == !$past(captured.phy_mode_select[0]))
    else $error("forced 10 mode wrong");

  boot_app_a: assert property (@(posedge pclk) disable iff (!presetn)
    strap_valid && !captured.boot_select |=> app_jump && !boot_rom_enable && app_start_addr == 16'h0)
    else $error("application boot wrong");

  boot_rom_a: assert property (@(posedge pclk) disable iff (!presetn)
    strap_valid && captured.boot_select |=> boot_rom_enable && !app_jump)
    else $error("boot rom not enabled");

  pll_lock_a: assert property (@(posedge pclk) disable iff (!presetn)
    strap_valid |-> pll_lock_out == $past(pll_locked, 3))
    else $error("lock output not following pll");

  speed_led_a: assert property (@(posedge pclk) disable iff (!presetn)
    strap_valid && !phy_cfg.an_enable && !led_blank |=> link_speed_led == !$past(phy_cfg.force_100))
    else $error("speed indicator wrong");

  duplex_led_a: assert property (@(posedge pclk) disable iff (!presetn)
    strap_valid && !phy_cfg.an_enable && !led_blank |=> duplex_led == !$past(phy_cfg.force_full_duplex))
    else $error("duplex indicator wrong");

  strap_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    strap_valid |=> strap_valid && $stable(captured))
    else $error("straps changed after capture");

  // Main scenarios
  cap_done_c: cover property (@(posedge pclk) disable iff (!presetn) $rose(strap_valid));
  forced_c: cover property (@(posedge pclk) disable iff (!presetn) strap_valid && !phy_cfg.an_enable);
  an_led_c: cover property (@(posedge pclk) disable iff (!presetn) phy_cfg.an_enable && an_done_sync);
  apb_err_c: cover property (@(posedge pclk) disable iff (!presetn) pready && pslverr);
endmodule

/* hw/scd_pkg.sv */
// Constants, types and behaviour list for the strap configuration decoder
// Behaviour
// - Low reset pin resets all logic asynchronously
// - Test-mode select must be 0000 in service
// - PHY select 000: autoneg, advertise everything
// - PHY select 001: autoneg, 100 Mbit only
// - PHY select 010: autoneg, 10 Mbit only
// - Select 100/101: forced 100 Mbit full/half
// - Select 110/111: forced 10 Mbit full/half
// - Boot select low: run application at 0x0000
// - Boot select high: run internal boot ROM loader
// - PLL lock output reports internal PLL lock
// - Speed indicator low at 100, high at 10
// - Duplex indicator low full, high half
package scd_pkg;
  // Strap widths and synchroniser width
  localparam int SCD_TM_W = 4;
  localparam int SCD_PM_W = 3;
  localparam int SCD_SYNC_W = 12;
  // Edges after reset release before straps are trusted
  localparam logic [2:0] SCD_CAPTURE_WAIT = 3'h4;
  localparam logic [3:0] SCD_TM_NORMAL = 4'h0;
  // PHY mode codes
  localparam logic [2:0] SCD_PM_AN_ALL = 3'h0;
  localparam logic [2:0] SCD_PM_AN_100 = 3'h1;
  localparam logic [2:0] SCD_PM_AN_10 = 3'h2;
  localparam logic [2:0] SCD_PM_RESERVED = 3'h3;
  localparam logic [2:0] SCD_PM_F100_FULL = 3'h4;
  localparam logic [2:0] SCD_PM_F100_HALF = 3'h5;
  localparam logic [2:0] SCD_PM_F10_FULL = 3'h6;
  localparam logic [2:0] SCD_PM_F10_HALF = 3'h7;
  // Advertised abilities: {100 full, 100 half, 10 full, 10 half}
  localparam logic [3:0] SCD_ADV_ALL = 4'hf;
  localparam logic [3:0] SCD_ADV_100 = 4'hc;
  localparam logic [3:0] SCD_ADV_10 = 4'h3;
  localparam logic [3:0] SCD_ADV_NONE = 4'h0;
  // Application start address
  localparam logic [15:0] SCD_APP_START = 16'h0000;
  // APB register byte offsets
  localparam logic [7:0] SCD_OFF_STRAP = 8'h00;
  localparam logic [7:0] SCD_OFF_STATUS = 8'h04;
  localparam logic [7:0] SCD_OFF_CTRL = 8'h08;
  // STRAP register fields
  localparam int SCD_ST_TM_LSB = 0;
  localparam int SCD_ST_PM_LSB = 4;
  localparam int SCD_ST_BOOT = 8;
  localparam int SCD_ST_VALID = 9;
  localparam int SCD_ST_RSVD = 10;
  localparam int SCD_ST_TEST = 11;
  // STATUS register fields
  localparam int SCD_SS_PLL = 0;
  localparam int SCD_SS_AN_DONE = 1;
  localparam int SCD_SS_SPEED100 = 2;
  localparam int SCD_SS_FULL = 3;
  // CTRL register fields
  localparam int SCD_CT_BLANK = 0;
  localparam int SCD_CT_RESTART = 1;
  // Captured strap set
  typedef struct packed {
    logic [3:0] test_mode_select;
    logic [2:0] phy_mode_select;
    logic boot_select;
  } scd_strap_type;
  // PHY operating configuration
  typedef struct packed {
    logic an_enable;
    logic [3:0] adv;
    logic force_100;
    logic force_full_duplex;
    logic reserved;
  } scd_phy_cfg_type;
endpackage

/* hw/scd_sync.sv */
// Two-stage synchroniser for asynchronous strap and status inputs
`timescale 1ns/10ps
module scd_sync #(
  parameter int WIDTH = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  // First stage, read only by the second stage
  logic [WIDTH-1:0] meta;

  // Both stages clear to zero, matching the pulled-down pins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule

/* hw/scd_phy_decode.sv */
// PHY mode strap decoder: autoneg abilities or forced speed and duplex
`timescale 1ns/10ps
module scd_phy_decode (
  input wire logic [2:0] phy_mode_select,
  output scd_pkg::scd_phy_cfg_type cfg
);
  // Pure decode; the top registers the result
  always_comb
  begin
    cfg = '0;
    case (phy_mode_select)
      scd_pkg::SCD_PM_AN_ALL:
      begin
        cfg.an_enable = 1'b1;
        cfg.adv = scd_pkg::SCD_ADV_ALL;
      end
      scd_pkg::SCD_PM_AN_100:
      begin
        cfg.an_enable = 1'b1;
        cfg.adv = scd_pkg::SCD_ADV_100;
      end
      scd_pkg::SCD_PM_AN_10:
      begin
        cfg.an_enable = 1'b1;
        cfg.adv = scd_pkg::SCD_ADV_10;
      end
      // Reserved code: fall back to full autoneg but flag it
      scd_pkg::SCD_PM_RESERVED:
      begin
        cfg.an_enable = 1'b1;
        cfg.adv = scd_pkg::SCD_ADV_ALL;
        cfg.reserved = 1'b1;
      end
      scd_pkg::SCD_PM_F100_FULL:
      begin
        cfg.force_100 = 1'b1;
        cfg.force_full_duplex = 1'b1;
      end
      scd_pkg::SCD_PM_F100_HALF:
      begin
        cfg.force_100 = 1'b1;
      end
      scd_pkg::SCD_PM_F10_FULL:
      begin
        cfg.force_full_duplex = 1'b1;
      end
      default:
      begin
        cfg.adv = scd_pkg::SCD_ADV_NONE;
      end
    endcase
  end
endmodule

/* bench/scd_board_model.sv */
// Board model: power-on reset circuit and strap pins with pull-downs
`timescale 1ns/10ps
module scd_board_model (
  input wire logic pclk,
  input wire logic por_req,
  input wire logic strap_en,
  input wire logic [3:0] tm_in,
  input wire logic [2:0] pm_in,
  input wire logic boot_in,
  output logic presetn,
  output logic [3:0] test_mode_select,
  output logic [2:0] phy_mode_select,
  output logic boot_select
);
  logic [2:0] rst_cnt; // Edges of reset still to hold
  // Reset drops at once on request, releases four edges after it
  always_ff @(posedge pclk or posedge por_req)
  begin
    if (por_req)
    begin
      rst_cnt <= 3'h4;
    end
    else if (rst_cnt != 3'h0)
    begin
      rst_cnt <= rst_cnt - 3'h1;
    end
  end
  assign presetn = (rst_cnt == 3'h0);
  // Released straps fall to their pull-down level, never keep the old value
  assign test_mode_select = strap_en ? tm_in : 4'h0;
  assign phy_mode_select = strap_en ? pm_in : 3'h0;
  assign boot_select = strap_en ? boot_in : 1'b0;
endmodule

/* bench/scd_top_tb_top.sv */
// Self-checking bench for the strap decoder: straps, LEDs, PLL and APB registers
`timescale 1ns/10ps
module scd_top_tb_top;
  logic pclk, presetn, por_req, strap_en, boot_in, psel, penable, pwrite;
  logic [3:0] tm_in, test_mode_select, pstrb;
  logic [2:0] pm_in, phy_mode_select;
  logic boot_select, pready, pslverr, pll_locked, an_complete, an_speed_100, an_full_duplex;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic err, pll_lock_out, an_restart, boot_rom_enable, app_jump, test_mode_active, strap_valid;
  logic link_speed_led, duplex_led;
  logic [15:0] app_start_addr;
  scd_pkg::scd_phy_cfg_type phy_cfg, e;
  int mismatches, num_checks, seen;
  // 20 MHz clock
  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  scd_board_model u_board (.pclk(pclk), .por_req(por_req), .strap_en(strap_en), .tm_in(tm_in),
    .pm_in(pm_in), .boot_in(boot_in), .presetn(presetn), .test_mode_select(test_mode_select),
    .phy_mode_select(phy_mode_select), .boot_select(boot_select));
  scd_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .test_mode_select(test_mode_select), .phy_mode_select(phy_mode_select), .boot_select(boot_select),
    .pll_locked(pll_locked), .an_complete(an_complete), .an_speed_100(an_speed_100),
    .an_full_duplex(an_full_duplex), .pll_lock_out(pll_lock_out), .phy_cfg(phy_cfg),
    .an_restart(an_restart), .boot_rom_enable(boot_rom_enable), .app_jump(app_jump),
    .app_start_addr(app_start_addr), .test_mode_active(test_mode_active), .strap_valid(strap_valid),
    .link_speed_led(link_speed_led), .duplex_led(duplex_led));
  // Counts, then the verdict; the only place the run ends
  task print_verdict();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Compare and report
  // Wide enough for an error flag beside a full data word
  task chk(input logic [32:0] got, input logic [32:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Bounded wait on strap_valid (sel 0) or pll_lock_out (sel 1)
  task wait_sig(input int sel, input logic lvl);
    logic v;
    for (int n = 0; n < 40; n++)
    begin
      @(posedge pclk);
      v = (sel == 0) ? strap_valid : pll_lock_out;
      if (v === lvl)
        return;
    end
    mismatches++;
    print_verdict();
  endtask
  // One APB transfer; request held until pready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20)
    begin
      mismatches++;
      print_verdict();
    end
  endtask
  // Expected PHY setup for each strap code; reserved code acts as code 0 with the reserved bit set
  function automatic scd_pkg::scd_phy_cfg_type exp_cfg(input logic [2:0] pm);
    case (pm)
      3'h1: exp_cfg = {1'b1, scd_pkg::SCD_ADV_100, 3'h0};
      3'h2: exp_cfg = {1'b1, scd_pkg::SCD_ADV_10, 3'h0};
      3'h4: exp_cfg = {1'b0, scd_pkg::SCD_ADV_NONE, 3'h6};
      3'h5: exp_cfg = {1'b0, scd_pkg::SCD_ADV_NONE, 3'h4};
      3'h6: exp_cfg = {1'b0, scd_pkg::SCD_ADV_NONE, 3'h2};
      3'h7: exp_cfg = {1'b0, scd_pkg::SCD_ADV_NONE, 3'h0};
      default: exp_cfg = {1'b1, scd_pkg::SCD_ADV_ALL, 2'h0, pm == 3'h3};
    endcase
  endfunction
  // Apply straps, pulse reset, check reset state, wait for capture
  task do_reset(input logic [3:0] tm, input logic [2:0] pm, input logic boot);
    @(posedge pclk);
    strap_en <= 1'b1;
    tm_in <= tm;
    pm_in <= pm;
    boot_in <= boot;
    por_req <= 1'b1;
    @(posedge pclk);
    por_req <= 1'b0;
    #1;
    chk({strap_valid, pll_lock_out, link_speed_led, duplex_led}, 32'h3);
    wait_sig(0, 1'b1);
    repeat (2) @(posedge pclk);
    #1;
  endtask
  // Main sequence
  initial
  begin
    {por_req, strap_en, tm_in, pm_in, boot_in, psel, penable, pwrite, paddr, pwdata} = '0;
    {pll_locked, an_complete, an_speed_100, an_full_duplex} = '0;
    pstrb = 4'hf;
    mismatches = 0;
    num_checks = 0;
    por_req = 1'b1;
    repeat (4) @(posedge pclk);
    // Every PHY code, both boot levels, one illegal test code
    for (int pm = 0; pm < 8; pm++)
    begin
      do_reset((pm == 5) ? 4'h9 : 4'h0, pm[2:0], pm[0]);
      e = exp_cfg(pm[2:0]);
      chk({phy_cfg.an_enable, phy_cfg.adv, phy_cfg.reserved}, {e.an_enable, e.adv, e.reserved});
      if (!e.an_enable)
        chk({phy_cfg.force_100, phy_cfg.force_full_duplex}, {e.force_100, e.force_full_duplex});
      chk({boot_rom_enable, app_jump, app_start_addr}, {pm[0], ~pm[0], 16'h0000});
      chk(test_mode_active, pm == 5);
      apb(1'b0, scd_pkg::SCD_OFF_STRAP, 32'h0);
      chk(rd, {20'h0, pm == 5, pm == 3, 2'b11 & {1'b1, pm[0]}, 1'b0, pm[2:0], tm_in});
      strap_en <= 1'b0;
      repeat (4) @(posedge pclk);
      #1;
      chk({phy_cfg.adv, boot_rom_enable, test_mode_active}, {e.adv, pm[0], pm == 5});
      if (e.an_enable)
        chk({link_speed_led, duplex_led}, 32'h3);
      // Status pins change on a rising edge, like every other input
      @(posedge pclk);
      an_complete <= 1'b1;
      an_speed_100 <= pm[1];
      an_full_duplex <= pm[0];
      repeat (5) @(posedge pclk);
      #1;
      if (e.an_enable)
        chk({link_speed_led, duplex_led}, {~pm[1], ~pm[0]});
      else
        chk({link_speed_led, duplex_led}, {~e.force_100, ~e.force_full_duplex});
      apb(1'b0, scd_pkg::SCD_OFF_STATUS, 32'h0);
      if (e.an_enable)
        chk(rd, {28'h0, pm[0], pm[1], 2'b10});
      else
        chk(rd, {28'h0, e.force_full_duplex, e.force_100, 2'b10});
      apb(1'b1, scd_pkg::SCD_OFF_CTRL, 32'h2);
      an_complete <= 1'b0;
      seen = 0;
      repeat (5)
      begin
        @(posedge pclk);
        #1;
        seen += an_restart;
      end
      chk(seen, e.an_enable);
      $display("test strap code %0d done", pm);
    end
    // Register side: blanking, read-only strap word, unmapped offset
    do_reset(4'h0, 3'h4, 1'b0);
    apb(1'b1, scd_pkg::SCD_OFF_CTRL, 32'h1);
    // Blanking lands at the write edge, the pins follow one edge later
    @(posedge pclk);
    #1;
    chk({link_speed_led, duplex_led}, 32'h3);
    apb(1'b0, scd_pkg::SCD_OFF_CTRL, 32'h0);
    chk({err, rd}, 33'h1);
    apb(1'b1, scd_pkg::SCD_OFF_CTRL, 32'h0);
    @(posedge pclk);
    #1;
    chk({link_speed_led, duplex_led}, 32'h0);
    apb(1'b1, scd_pkg::SCD_OFF_STRAP, 32'hffffffff);
    apb(1'b0, scd_pkg::SCD_OFF_STRAP, 32'h0);
    chk(rd, 32'h240);
    apb(1'b0, 8'h0c, 32'h0);
    chk({err, rd}, {1'b1, 32'h0});
    $display("test registers done");
    // PLL lock follows the raw lock both ways
    pll_locked <= 1'b1;
    wait_sig(1, 1'b1);
    apb(1'b0, scd_pkg::SCD_OFF_STATUS, 32'h0);
    chk(rd[0], 1'b1);
    pll_locked <= 1'b0;
    wait_sig(1, 1'b0);
    chk(pll_lock_out, 1'b0);
    $display("test pll lock done");
    print_verdict();
  end
endmodule
